/* ctt_regs.vh */
// Purpose: register map, field positions and reset values of the timer trio
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef CTT_REGS_VH
`define CTT_REGS_VH

// register byte offsets
`define CTT_OFS_MODE      8'h00
`define CTT_OFS_RUN       8'h04
`define CTT_OFS_T0        8'h08
`define CTT_OFS_T1        8'h0C
`define CTT_OFS_T2CTL     8'h10
`define CTT_OFS_T2CNT     8'h14
`define CTT_OFS_T2RLD     8'h18

// timer_mode fields
`define CTT_T1_GATE       7
`define CTT_T1_CSEL       6
`define CTT_T1_MODE_HI    5
`define CTT_T1_MODE_LO    4
`define CTT_T0_GATE       3
`define CTT_T0_CSEL       2
`define CTT_T0_MODE_HI    1
`define CTT_T0_MODE_LO    0

// timer_run fields
`define CTT_RUN0          0
`define CTT_RUN1          1
`define CTT_FLAG0         2
`define CTT_FLAG1         3

// timer2_control fields
`define CTT_T2_OVF        7
`define CTT_T2_EDGE       6
`define CTT_T2_RCLK       5
`define CTT_T2_UART_TX_CLOCK_SELECT       4
`define CTT_T2_EXEN       3
`define CTT_T2_RUN        2
`define CTT_T2_CSEL       1
`define CTT_T2_CPRL       0

// operating modes of timers 0 and 1
`define CTT_MODE13        2'h0
`define CTT_MODE16        2'h1
`define CTT_MODE8R        2'h2
`define CTT_MODESPLIT     2'h3

// reset values
`define CTT_RST8          8'h00
`define CTT_RST16         16'h0000

// bus responses
`define CTT_RESP_OKAY     2'h0
`define CTT_RESP_SLVERR   2'h2

`endif

/* ctt_timers.v */
// Purpose: timers 0 and 1 (four modes) and timer 2 with baud tick select
// Assumes: one clock, all pins synchronous to aclk, AXI4-Lite register access
// Notes:   external pins count on falling edges seen between two clocks
// Summary of operation
// - mode 0: low byte is 5-bit prescaler into 8-bit high byte, 13 bits
// - mode 1: full low byte cascades into high byte, 16-bit counter
// - mode 2: low byte counts 8 bits, high byte holds reload value
// - mode 2: low byte overflow reloads low byte from high byte
// - mode 3 only on timer 0: two independent 8-bit counters
// - split: low uses timer 0 run and flag, high uses timer 1's
// - timer 2 works as reload counter, capture timer or baud generator
// - timer 2 overflow flag stays set until software clears it
// - timer 2 overflow flag never set while rx or tx clock select set
// - edge flag set on external pin falling edge when enabled and timer 2 runs; software clears
// - rx select 1 picks timer 2 overflow ticks, 0 timer 1 overflows
// - tx select 1 picks timer 2 overflow ticks, 0 timer 1 overflows
// - gate bit set makes the gate pin also qualify counting
// - counter select counts external pin edges, clear counts clock
// - auto-reload: overflow sets flag and reloads from reload pair
// - capture: enabled external falling edge while timer 2 runs copies count into reload pair
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ctt_regs.vh"

module ctt_timers (
  input  wire        aclk,            // system clock, 250 MHz
  input  wire        aresetn,         // synchronous reset, active low
  input  wire [7:0]  s_axi_awaddr,    // write address
  input  wire        s_axi_awvalid,   // write address valid
  output wire        s_axi_awready,   // write address ready
  input  wire [31:0] s_axi_wdata,     // write data
  input  wire [3:0]  s_axi_wstrb,     // write byte lanes
  input  wire        s_axi_wvalid,    // write data valid
  output wire        s_axi_wready,    // write data ready
  output reg  [1:0]  s_axi_bresp,     // write response
  output reg         s_axi_bvalid,    // write response valid
  input  wire        s_axi_bready,    // write response ready
  input  wire [7:0]  s_axi_araddr,    // read address
  input  wire        s_axi_arvalid,   // read address valid
  output wire        s_axi_arready,   // read address ready
  output reg  [31:0] s_axi_rdata,     // read data
  output reg  [1:0]  s_axi_rresp,     // read response
  output reg         s_axi_rvalid,    // read data valid
  input  wire        s_axi_rready,    // read data ready
  input  wire        t0_count_pin,    // timer 0 external count input
  input  wire        t1_count_pin,    // timer 1 external count input
  input  wire        t0_gate_pin,     // timer 0 external gate input
  input  wire        t1_gate_pin,     // timer 1 external gate input
  input  wire        t2_count_pin,    // timer 2 external count input
  input  wire        t2_external_pin, // timer 2 capture/reload input
  output reg         uart_rx_tick,    // primary_serial_port receive baud tick
  output reg         uart_tx_tick,    // primary_serial_port transmit baud tick
  output reg         t1_overflow      // timer 1 overflow pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg  [7:0]  mode_r;
  reg         run0, run1, flag0, flag1;
  reg  [7:0]  t0_low_counter, t0_high_counter;
  reg  [7:0]  t1_low, t1_high;
  reg  [7:0]  t2ctl;
  reg  [15:0] t2_count, t2_reload;
  reg         t0_pin_q, t1_pin_q, t2_pin_q, t2x_pin_q;
  reg         aw_held, w_held;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;

  reg  [7:0]  next_mode;
  reg         next_run0, next_run1, next_flag0, next_flag1;
  reg  [7:0]  next_t0l, next_t0h, next_t1l, next_t1h;
  reg  [7:0]  next_t2ctl;
  reg  [15:0] next_t2cnt, next_t2rld;
  reg         next_rx, next_tx;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // one count step of timer 0/1: {overflow, high, low}
  function [16:0] step;
    input [1:0] m;
    input [7:0] lo;
    input [7:0] hi;
    input       go;
    reg   [8:0] s;
    begin
      step = {1'b0, hi, lo};
      s = {1'b0, hi} + 9'h001;
      if (go)
      begin
        case (m)
          `CTT_MODE13:
          begin
            if (lo[4:0] == 5'h1F)
              step = {s, lo[7:5], 5'h00};
            else
              step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
          end
          `CTT_MODE16: step = {1'b0, hi, lo} + 17'h00001;
          `CTT_MODE8R:
          begin
            if (lo == 8'hFF)
              step = {1'b1, hi, hi};
            else
              step = {1'b0, hi, lo + 8'h01};
          end
          default: step = {lo == 8'hFF, hi, lo + 8'h01};
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one write and one read at a time
  wire wr_do = aw_held & w_held & ~s_axi_bvalid;
  wire [31:0] wr_word = w_data_q;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire wr_hit  = (aw_addr_q[7:5] == 3'h0) && (aw_addr_q[4:2] != 3'h7);
  wire rd_hit  = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[4:2] != 3'h7);
  wire sel_mode = wr_do && aw_addr_q[7:2] == `CTT_OFS_MODE >> 2;
  wire sel_run  = wr_do && aw_addr_q[7:2] == `CTT_OFS_RUN >> 2;
  wire sel_t0   = wr_do && aw_addr_q[7:2] == `CTT_OFS_T0 >> 2;
  wire sel_t1   = wr_do && aw_addr_q[7:2] == `CTT_OFS_T1 >> 2;
  wire sel_t2c  = wr_do && aw_addr_q[7:2] == `CTT_OFS_T2CTL >> 2;
  wire sel_t2n  = wr_do && aw_addr_q[7:2] == `CTT_OFS_T2CNT >> 2;
  wire sel_t2r  = wr_do && aw_addr_q[7:2] == `CTT_OFS_T2RLD >> 2;

  reg [31:0] rd_mux;
  always @*
  begin
    case (s_axi_araddr[7:0] & 8'hFC)
      `CTT_OFS_MODE:  rd_mux = {24'h000000, mode_r};
      `CTT_OFS_RUN:   rd_mux = {28'h0000000, flag1, flag0, run1, run0};
      `CTT_OFS_T0:    rd_mux = {16'h0000, t0_high_counter, t0_low_counter};
      `CTT_OFS_T1:    rd_mux = {16'h0000, t1_high, t1_low};
      `CTT_OFS_T2CTL: rd_mux = {24'h000000, t2ctl};
      `CTT_OFS_T2CNT: rd_mux = {16'h0000, t2_count};
      `CTT_OFS_T2RLD: rd_mux = {16'h0000, t2_reload};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // count logic
  wire [1:0] m0 = mode_r[`CTT_T0_MODE_HI:`CTT_T0_MODE_LO];
  wire [1:0] m1 = mode_r[`CTT_T1_MODE_HI:`CTT_T1_MODE_LO];
  wire split = (m0 == `CTT_MODESPLIT);
  wire t0_fall = t0_pin_q & ~t0_count_pin;
  wire t1_fall = t1_pin_q & ~t1_count_pin;
  wire t2_fall = t2_pin_q & ~t2_count_pin;
  wire t2x_fall = t2x_pin_q & ~t2_external_pin;
  wire go0 = run0 & (~mode_r[`CTT_T0_GATE] | t0_gate_pin)
           & (mode_r[`CTT_T0_CSEL] ? t0_fall : 1'b1);
  // timer 1 holds in its own mode 3
  wire go1 = run1 & (~mode_r[`CTT_T1_GATE] | t1_gate_pin)
           & (mode_r[`CTT_T1_CSEL] ? t1_fall : 1'b1)
           & (m1 != `CTT_MODESPLIT);
  wire [16:0] s0 = step(m0, t0_low_counter, t0_high_counter, go0);
  wire [16:0] s1 = step(m1, t1_low, t1_high, go1);
  wire        hi_go  = split & run1;
  wire [8:0]  hi_sum = {1'b0, t0_high_counter} + 9'h001;
  wire        t1_ovf = s1[16];

  wire baud  = t2ctl[`CTT_T2_RCLK] | t2ctl[`CTT_T2_UART_TX_CLOCK_SELECT];
  wire t2run = t2ctl[`CTT_T2_RUN];
  wire cprl  = t2ctl[`CTT_T2_CPRL];
  wire t2_go = t2run & (t2ctl[`CTT_T2_CSEL] ? t2_fall : 1'b1);
  wire t2_wrap = t2_go & (t2_count == 16'hFFFF);
  wire x_ev = t2run & t2ctl[`CTT_T2_EXEN] & t2x_fall;

  // byte-lane merges of the pending write, cut to register width where used
  wire [31:0] mrg_mode = merge({24'h000000, mode_r}, wr_word, w_strb_q);
  wire [31:0] mrg_t0   = merge({16'h0000, t0_high_counter, t0_low_counter}, wr_word, w_strb_q);
  wire [31:0] mrg_t1   = merge({16'h0000, t1_high, t1_low}, wr_word, w_strb_q);
  wire [31:0] mrg_t2c  = merge({24'h000000, t2ctl}, wr_word, w_strb_q);
  wire [31:0] mrg_t2n  = merge({16'h0000, t2_count}, wr_word, w_strb_q);
  wire [31:0] mrg_t2r  = merge({16'h0000, t2_reload}, wr_word, w_strb_q);

  always @*
  begin
    next_mode  = sel_mode ? mrg_mode[7:0] : mode_r;
    next_run0  = run0;
    next_run1  = run1;
    next_flag0 = flag0;
    next_flag1 = flag1;
    if (sel_run && w_strb_q[0])
    begin
      next_run0  = wr_word[`CTT_RUN0];
      next_run1  = wr_word[`CTT_RUN1];
      next_flag0 = wr_word[`CTT_FLAG0];
      next_flag1 = wr_word[`CTT_FLAG1];
    end
    // set wins over a same-cycle software clear
    if (s0[16])
      next_flag0 = 1'b1;
    if (split ? (hi_go & hi_sum[8]) : t1_ovf)
      next_flag1 = 1'b1;
    next_t0l = s0[7:0];
    next_t0h = split ? (hi_go ? hi_sum[7:0] : t0_high_counter) : s0[15:8];
    next_t1l = s1[7:0];
    next_t1h = s1[15:8];
    if (sel_t0)
      {next_t0h, next_t0l} = mrg_t0[15:0];
    if (sel_t1)
      {next_t1h, next_t1l} = mrg_t1[15:0];

    // timer 2
    next_t2ctl = sel_t2c ? mrg_t2c[7:0] : t2ctl;
    if (t2_wrap && !baud)
      next_t2ctl[`CTT_T2_OVF] = 1'b1;
    if (x_ev)
      next_t2ctl[`CTT_T2_EDGE] = 1'b1;
    next_t2cnt = t2_count;
    next_t2rld = t2_reload;
    if (t2_wrap)
      next_t2cnt = (baud || !cprl) ? t2_reload : `CTT_RST16;
    else if (t2_go)
      next_t2cnt = t2_count + 16'h0001;
    if (x_ev && !baud && !cprl)
      next_t2cnt = t2_reload;
    if (x_ev && !baud && cprl)
      next_t2rld = t2_count;
    if (sel_t2n)
      next_t2cnt = mrg_t2n[15:0];
    if (sel_t2r)
      next_t2rld = mrg_t2r[15:0];

    next_rx = t2ctl[`CTT_T2_RCLK] ? t2_wrap : t1_ovf;
    next_tx = t2ctl[`CTT_T2_UART_TX_CLOCK_SELECT] ? t2_wrap : t1_ovf;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_r <= `CTT_RST8;
      {run0, run1, flag0, flag1} <= 4'h0;
      t0_low_counter <= `CTT_RST8;
      t0_high_counter <= `CTT_RST8;
      t1_low <= `CTT_RST8;
      t1_high <= `CTT_RST8;
      t2ctl <= `CTT_RST8;
      t2_count <= `CTT_RST16;
      t2_reload <= `CTT_RST16;
      {t0_pin_q, t1_pin_q, t2_pin_q, t2x_pin_q} <= 4'h0;
      {uart_rx_tick, uart_tx_tick, t1_overflow} <= 3'h0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CTT_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CTT_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      mode_r <= next_mode;
      run0 <= next_run0;
      run1 <= next_run1;
      flag0 <= next_flag0;
      flag1 <= next_flag1;
      t0_low_counter <= next_t0l;
      t0_high_counter <= next_t0h;
      t1_low <= next_t1l;
      t1_high <= next_t1h;
      t2ctl <= next_t2ctl;
      t2_count <= next_t2cnt;
      t2_reload <= next_t2rld;
      {t0_pin_q, t1_pin_q} <= {t0_count_pin, t1_count_pin};
      {t2_pin_q, t2x_pin_q} <= {t2_count_pin, t2_external_pin};
      uart_rx_tick <= next_rx;
      uart_tx_tick <= next_tx;
      t1_overflow <= t1_ovf;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `CTT_RESP_OKAY : `CTT_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `CTT_RESP_OKAY : `CTT_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ctt_timers
`default_nettype wire

/* ctt_timers_asserts.sv */
// Purpose: port-level checks for ctt_timers
// Assumes: write address and data are offered together
// Notes:   baud selects are shadowed from bus writes to timer2_control
`timescale 1ns/1ps
`default_nettype none
module ctt_timers_asserts (
  input wire logic        aclk,          // clock
  input wire logic        aresetn,       // reset, low
  input wire logic [7:0]  s_axi_awaddr,  // aw addr
  input wire logic        s_axi_awvalid, // aw valid
  input wire logic        s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata,   // w data
  input wire logic [3:0]  s_axi_wstrb,   // w lanes
  input wire logic        s_axi_wvalid,  // w valid
  input wire logic        s_axi_wready,  // w ready
  input wire logic [1:0]  s_axi_bresp,   // b resp
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic [7:0]  s_axi_araddr,  // ar addr
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata,   // r data
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready,  // r ready
  input wire logic        uart_rx_tick,  // rx baud
  input wire logic        uart_tx_tick,  // tx baud
  input wire logic        t1_overflow    // t1 wrap
);
  logic [7:0] pend;
  logic       pv;
  logic [7:0] ctl;
  logic [7:0] ar_last;
  wire        wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  ////////////////////////////////////////
  // shadow lands at the edge the write is applied, like the register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pv  <= 1'b0;
      ctl <= 8'h00;
    end
    else
    begin
      pv <= wr_go && s_axi_awaddr == 8'h10 && s_axi_wstrb[0];
      if (pv)
        ctl <= pend;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (wr_go)
      pend <= s_axi_wdata[7:0];
    if (s_axi_arvalid && s_axi_arready)
      ar_last <= s_axi_araddr;
  end
  ////////////////////////////////////////
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  write_answer_a: assert property (wr_go |=> ##1 s_axi_bvalid)
    else $error("write response late");
  // three quiet cycles hide the tick register lagging a select change
  rx_source_a: assert property ((!ctl[5])[*3] |-> uart_rx_tick == t1_overflow)
    else $error("rx tick not from timer 1");
  tx_source_a: assert property ((!ctl[4])[*3] |-> uart_tx_tick == t1_overflow)
    else $error("tx tick not from timer 1");
  baud_pair_a: assert property ((ctl[5] && ctl[4])[*3] |-> uart_rx_tick == uart_tx_tick)
    else $error("timer 2 ticks differ");
  baud_flag_a: assert property (s_axi_rvalid && ar_last == 8'h10 && (ctl[5] || ctl[4]) && !ctl[7]
    |-> !s_axi_rdata[7])
    else $error("overflow flag set in baud mode");
endmodule // ctt_timers_asserts
bind ctt_timers ctt_timers_asserts ctt_timers_asserts_i (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .uart_rx_tick, .uart_tx_tick, .t1_overflow);
`default_nettype wire

/* ctt_far_end.sv */
// Purpose: external pins and baud tick counter facing the timer trio
// Assumes: pins change just after a rising clock edge
// Notes:   count pins idle high so only commanded pulses count
`timescale 1ns/1ps
`default_nettype none
module ctt_far_end (
  input  wire logic aclk,            // clock
  input  wire logic uart_rx_tick,    // rx baud
  input  wire logic uart_tx_tick,    // tx baud
  output logic      t0_count_pin,    // t0 count
  output logic      t1_count_pin,    // t1 count
  output logic      t2_count_pin,    // t2 count
  output logic      t2_external_pin, // t2 capture
  output logic      t0_gate_pin,     // t0 gate
  output logic      t1_gate_pin      // t1 gate
);
  logic [3:0]  fall_pin = 4'hF;
  logic [1:0]  gate_pin = 2'h0;
  logic [31:0] rx_n = 32'h0;
  logic [31:0] tx_n = 32'h0;
  assign t0_count_pin    = fall_pin[0];
  assign t1_count_pin    = fall_pin[1];
  assign t2_count_pin    = fall_pin[2];
  assign t2_external_pin = fall_pin[3];
  assign t0_gate_pin     = gate_pin[0];
  assign t1_gate_pin     = gate_pin[1];
  ////////////////////////////////////////
  always @(posedge aclk)
  begin
    // ticks are unknown before the first reset edge; only a clean 1 counts
    if (uart_rx_tick)
      rx_n <= rx_n + 32'h1;
    if (uart_tx_tick)
      tx_n <= tx_n + 32'h1;
  end
  // low one cycle then high: one falling edge per call
  task automatic fall(input int k);
    fall_pin[k] <= 1'b0;
    @(posedge aclk);
    fall_pin[k] <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic gate(input int k, input logic g);
    gate_pin[k] <= g;
  endtask
endmodule // ctt_far_end
`default_nettype wire

/* test_classic_timer_trio.sv */
// Purpose: self-checking bench for the timer trio
// Assumes: 250 MHz aclk, results checked by a monitor off queues
// Notes:   count pins only move by far-end pulses, so counts are exact
`timescale 1ns/1ps
`default_nettype none
`include "ctt_regs.vh"
module test_classic_timer_trio;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_rready;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         t0_count_pin, t1_count_pin, t2_count_pin, t2_external_pin;
  wire         t0_gate_pin, t1_gate_pin, uart_rx_tick, uart_tx_tick, t1_overflow;
  logic [65:0] q_r[$];
  logic [1:0]  q_b[$];
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          seed;
  logic [31:0] v, rb, tb, rnd;
  // mode, gate pin, start count, expected count
  localparam logic [47:0] t0_tab [6] = '{48'h04_01_00FF_01E0,
    48'h05_01_00FF_0100, 48'h0D_00_00FF_00FF, 48'h0D_01_00FF_0100,
    48'h05_01_FFFF_0000, 48'h06_01_F0FF_F0F0};
  ctt_timers ctt_timers_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .t0_count_pin, .t1_count_pin, .t0_gate_pin, .t1_gate_pin,
    .t2_count_pin, .t2_external_pin, .uart_rx_tick, .uart_tx_tick, .t1_overflow);
  ctt_far_end ctt_far_end_i (.aclk, .uart_rx_tick, .uart_tx_tick, .t0_count_pin, .t1_count_pin,
    .t2_count_pin, .t2_external_pin, .t0_gate_pin, .t1_gate_pin);
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ready sampled at the rising edge; response ready raised early or late at random
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    rnd = $random(seed);
    q_b.push_back(a < 8'h1C ? `CTT_RESP_OKAY : `CTT_RESP_SLVERR);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= rnd[0];
    @(posedge aclk);
    while (s_axi_awvalid || s_axi_wvalid)
    begin
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      @(posedge aclk);
    end
    while (!(s_axi_bvalid && s_axi_bready))
    begin
      if (s_axi_bvalid)
        s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    rnd = $random(seed);
    q_r.push_back({a < 8'h1C ? `CTT_RESP_OKAY : `CTT_RESP_SLVERR, m, e & m});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= rnd[1];
    @(posedge aclk);
    while (!s_axi_arready)
      @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    while (!(s_axi_rvalid && s_axi_rready))
    begin
      if (s_axi_rvalid)
        s_axi_rready <= 1'b1;
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (s_axi_bvalid && s_axi_bready && q_b.size() > 0)
      chk("bresp", {30'h0, q_b.pop_front()}, {30'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready && q_r.size() > 0)
    begin
      chk("rdata", q_r[0][31:0], s_axi_rdata & q_r[0][63:32]);
      chk("rresp", {30'h0, q_r[0][65:64]}, {30'h0, s_axi_rresp});
      void'(q_r.pop_front());
    end
    if (cyc == 20000)
    begin
      err_total++;
      test_done;
    end
  end
  initial
  begin
    seed = 32'h5a8b060f;
    {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int a = 0; a < 32; a += 4)
      rd(a[7:0], 32'h0);
    wr(8'h1C, 32'hFF);
    wr(`CTT_OFS_RUN, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      wr(`CTT_OFS_MODE, {24'h0, t0_tab[i][47:40]});
      wr(`CTT_OFS_T0, {16'h0, t0_tab[i][31:16]});
      ctt_far_end_i.gate(0, t0_tab[i][32]);
      ctt_far_end_i.fall(0);
      rd(`CTT_OFS_T0, {16'h0, t0_tab[i][15:0]});
    end
    rd(`CTT_OFS_RUN, 32'h5);
    wr(`CTT_OFS_MODE, 32'hE0);
    wr(`CTT_OFS_T1, 32'hFFFF);
    wr(`CTT_OFS_RUN, 32'h2);
    ctt_far_end_i.gate(1, 1'b1);
    repeat (3) ctt_far_end_i.fall(1);
    rd(`CTT_OFS_RUN, 32'hA);
    chk("rx ticks", 32'h3, ctt_far_end_i.rx_n);
    chk("tx ticks", 32'h3, ctt_far_end_i.tx_n);
    wr(`CTT_OFS_RUN, 32'h0);
    wr(`CTT_OFS_T1, 32'h1234, 4'h2);
    rd(`CTT_OFS_T1, 32'h12FF); // only the strobed high byte lands
    wr(`CTT_OFS_MODE, 32'h03);
    wr(`CTT_OFS_T0, 32'hFF00);
    wr(`CTT_OFS_RUN, 32'h2);
    rd(`CTT_OFS_RUN, 32'hA);
    rd(`CTT_OFS_T0, 32'h0, 32'hFF);
    wr(`CTT_OFS_RUN, 32'h0);
    rb = ctt_far_end_i.rx_n;
    tb = ctt_far_end_i.tx_n;
    wr(`CTT_OFS_T2RLD, 32'hFFFE);
    wr(`CTT_OFS_T2CNT, 32'hFFFE);
    wr(`CTT_OFS_T2CTL, 32'h26);
    repeat (4) ctt_far_end_i.fall(2);
    rd(`CTT_OFS_T2CTL, 32'h26);
    wr(`CTT_OFS_T2CTL, 32'h16);
    repeat (4) ctt_far_end_i.fall(2);
    chk("rx ticks", rb + 2, ctt_far_end_i.rx_n);
    chk("tx ticks", tb + 2, ctt_far_end_i.tx_n);
    wr(`CTT_OFS_T2CNT, 32'hFFFF);
    wr(`CTT_OFS_T2CTL, 32'h06);
    ctt_far_end_i.fall(2);
    rd(`CTT_OFS_T2CNT, 32'hFFFE);
    rd(`CTT_OFS_T2CTL, 32'h86);
    wr(`CTT_OFS_T2CTL, 32'h82);
    repeat (2) ctt_far_end_i.fall(2);
    rd(`CTT_OFS_T2CNT, 32'hFFFE);
    rd(`CTT_OFS_T2CTL, 32'h82);
    v = $random(seed);
    wr(`CTT_OFS_T2CNT, v);
    wr(`CTT_OFS_T2CTL, 32'h0F);
    ctt_far_end_i.fall(3);
    rd(`CTT_OFS_T2RLD, v & 32'hFFFF);
    rd(`CTT_OFS_T2CTL, 32'h4F);
    wr(`CTT_OFS_T2CTL, 32'h06);
    ctt_far_end_i.fall(3);
    rd(`CTT_OFS_T2CTL, 32'h06);
    repeat (2) @(posedge aclk);
    test_done;
  end
endmodule // test_classic_timer_trio
`default_nettype wire
